// ===== bench/mhcd_partner.sv
// host side partner: slow consumer of replies and power-line packets
`timescale 1ns/10ps
`default_nettype none
module mhcd_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic reply_ready_o,
  output logic plc_ready_o
);
  // accept on alternate cycles so the design must hold what it offers
  always @(posedge clk_i) begin
    reply_ready_o <= rst_i ? 1'b0 : ~reply_ready_o;
    plc_ready_o <= rst_i ? 1'b1 : ~plc_ready_o;
  end
endmodule : mhcd_partner
`default_nettype wire

// ===== bench/mhcd_tb_top.sv
// self-checking bench of the command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module mhcd_tb_top import mhcd_pkg::*;;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic frame_valid_i = 0, plc_rx_valid_i = 0, wb_ack_o, frame_ready_o;
  logic reply_valid_o, reply_ready_i, plc_rx_ready_o, plc_tx_valid_o;
  logic plc_tx_ready_i, on_lamp_o;
  logic [7:0] wb_adr_i = 0, lamp_level_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic [15:0] frame_word_i = 0, reply_word_o;
  logic [11:0] link_evt_i = 0;
  mhcd_pkt_t plc_rx_i = '0, plc_tx_o;
  int bad_count = 0, cmp_count = 0, cyc_n = 0;
  // shortened counts keep the run brief
  mhcd_top #(.MS_CYC(10), .WORD_CYC(4)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o,
    .frame_valid_i, .frame_word_i, .frame_ready_o, .reply_valid_o, .reply_word_o,
    .reply_ready_i, .node_addr_i(16'h0100), .plc_rx_valid_i, .plc_rx_i,
    .plc_rx_ready_o, .plc_tx_valid_o, .plc_tx_o, .plc_tx_ready_i, .link_evt_i,
    .lamp_level_o, .on_lamp_o);
  mhcd_partner host (.clk_i, .rst_i, .reply_ready_o(reply_ready_i),
    .plc_ready_o(plc_tx_ready_i));
  always #5 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic frame(input logic [15:0] c, p1, p2 = 0, p3 = 0, p4 = 0, p5 = 0, p6 = 0);
    logic [6:0][15:0] v;
    v = {p6, p5, p4, p3, p2, p1, c};
    for (int i = 0; i < 32; i++) begin
      frame_valid_i <= 1'b1;
      frame_word_i <= i < 7 ? v[i] : 16'h0000;
      do @(posedge clk_i); while (frame_ready_o !== 1'b1);
    end
    frame_valid_i <= 1'b0;
  endtask : frame
  task automatic get(input logic [15:0] e);
    do @(posedge clk_i); while (reply_valid_o !== 1'b1 || reply_ready_i !== 1'b1);
    `CHK("reply", e, reply_word_o)
  endtask : get
  task automatic lamp(input logic [7:0] code, input logic on);
    frame(16'h000B, {8'h00, code});
    get(16'h0000);
    repeat (4) @(posedge clk_i);
    `CHK("lamp on", on, on_lamp_o)
  endtask : lamp
  task automatic dl(input logic [7:0] v);
    frame(16'h000A, {8'h00, v});
    get(16'h0000);
    repeat (100) @(posedge clk_i);
  endtask : dl
  task automatic rx(input mhcd_pkt_t p);
    plc_rx_valid_i <= 1'b1;
    plc_rx_i <= p;
    do @(posedge clk_i); while (plc_rx_ready_o !== 1'b1);
    plc_rx_valid_i <= 1'b0;
  endtask : rx
  task automatic tx(input logic [15:0] d, c);
    do @(posedge clk_i); while (plc_tx_valid_o !== 1'b1 || plc_tx_ready_i !== 1'b1);
    `CHK("tx dst", d, plc_tx_o.dst)
    `CHK("tx cmd", c, plc_tx_o.cmd)
  endtask : tx
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    link_evt_i <= 12'h001;
    repeat (2) @(posedge clk_i);
    link_evt_i <= 12'h000;
    wb(0, 8'h00, 0);
    `CHK("limits", 32'h0000FE01, rd)
    wb(1, 8'h00, 32'h0000FE02);
    wb(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, rd)
    frame(16'h0005, 0);
    get(16'h0001);
    frame(16'h000F, 0);
    get(16'h0000);
    get(16'h0100);
    $display("test 1 done");
    frame(2, 0, 2, 16'h0005, 16'h1234, 16'h0006, 16'hBEEF);
    get(16'h0000);
    frame(1, 0, 2, 16'h0005, 16'h0006);
    get(16'h0000);
    get(16'h1234);
    get(16'hBEEF);
    frame(2, 1, 3, 16'h0100, 16'hABCD);
    get(16'h0000);
    frame(1, 1, 3, 16'h0100);
    get(16'h0000);
    repeat (3) get(16'hABCD);
    frame(1, 0, 30);
    get(16'h0002);
    frame(2, 0, 15);
    get(16'h0002);
    $display("test 2 done");
    lamp(8'd5, 1'b1);
    `CHK("level", 8'hFE, lamp_level_o)
    lamp(8'd6, 1'b1);
    `CHK("level", 8'h02, lamp_level_o)
    lamp(8'd200, 1'b1);
    `CHK("level", 8'h02, lamp_level_o)
    lamp(8'd0, 1'b0);
    lamp(8'd3, 1'b0);
    rx('{16'h0999, 16'h000B, 16'h0005, 16'h0, 16'h0});
    repeat (6) @(posedge clk_i);
    `CHK("lamp on", 1'b0, on_lamp_o)
    lamp(8'd8, 1'b1);
    lamp(8'h63, 1'b1);
    wb(0, 8'h10, 0);
    `CHK("group", 32'h00000008, rd)
    wb(1, 8'h04, 32'h00000001);
    wb(1, 8'h00, 32'h00000602);
    dl(8'hF0);
    `CHK("level", 8'h06, lamp_level_o)
    dl(8'h01);
    `CHK("level", 8'h02, lamp_level_o)
    dl(8'h00);
    `CHK("lamp on", 1'b0, on_lamp_o)
    $display("test 3 done");
    rx('{16'h0100, 16'h0021, 16'h0000, 16'h0007, 16'h0022});
    tx(16'h0007, 16'h0022);
    frame(16'h000C, 16'h0000, 16'h0044, 16'h000B, 16'h0005);
    tx(16'h0044, 16'h000B);
    get(16'h0000);
    frame(3, 0);
    get(16'h0000);
    get(16'h000F);
    get(16'h0002);
    repeat (12) get(16'h0000);
    get(16'h0001);
    get(16'h0000);
    frame(3, 1);
    get(16'h0000);
    frame(3, 0);
    get(16'h0000);
    get(16'h000F);
    repeat (15) get(16'h0000);
    $display("test 4 done");
    frame(16'h000D, 16'h0014);
    get(16'h0000);
    wb(0, 8'h0C, 0);
    `CHK("flood", 32'h000F0000, rd)
    frame(16'h0020, 2, 16'h0033, 0);
    get(16'h0000);
    repeat (3) get(16'h0000);
    wb(0, 8'h0C, 0);
    `CHK("echo cfg", 32'h00010033, rd)
    tx(16'h0033, 16'h0021);
    `CHK("tx ack", 16'h0022, plc_tx_o.p2)
    rx('{16'h0100, 16'h0022, 16'h0000, 16'h0033, 16'h0000});
    frame(16'h0020, 2, 16'h0033, 1);
    get(16'h0000);
    get(16'h0001);
    get(16'h0000);
    get(16'h0001);
    $display("test 5 done");
    end_of_test();
  end
endmodule : mhcd_tb_top
`default_nettype wire

// ===== design/mhcd_consts.svh
// constants of the modem host command decoder: codes, limits, offsets, timing
`ifndef MHCD_CONSTS_SVH
`define MHCD_CONSTS_SVH
`define MHCD_CLK_HZ 32'h05F5E100
`define MHCD_BAUD 32'h0001C200
`define MHCD_BITS_PER_WORD 32'h00000014
`define MHCD_MS_PER_S 32'h000003E8
`define MHCD_FLOOD_WRAP 11'h3E8
`define MHCD_FADE_WIN_MS 8'hC8
`define MHCD_FRAME_LAST 5'h1F
`define MHCD_LIST_MAX 16'h001D
`define MHCD_PAIR_MAX 16'h000E
`define MHCD_FLOOD_MAX 16'h000F
`define MHCD_N_LINK 12
`define MHCD_N_ERR 3
`define MHCD_SEQ_COUNT 16'h000F
`define MHCD_SEQ_ERR0 5'h0D
`define MHCD_SEQ_LAST 5'h0F
`define MHCD_SEQ_ADDR 5'h10
`define MHCD_CMD_RDMEM 16'h0001
`define MHCD_CMD_WRMEM 16'h0002
`define MHCD_CMD_STAT 16'h0003
`define MHCD_CMD_DLAMP 16'h000A
`define MHCD_CMD_LAMP 16'h000B
`define MHCD_CMD_PLCMSG 16'h000C
`define MHCD_CMD_FLOOD 16'h000D
`define MHCD_CMD_GETADDR 16'h000F
`define MHCD_CMD_ECHOSET 16'h0020
`define MHCD_CMD_ECHOREQ 16'h0021
`define MHCD_CMD_ECHOACK 16'h0022
`define MHCD_RC_OK 16'h0000
`define MHCD_RC_BADCMD 16'h0001
`define MHCD_RC_BADCNT 16'h0002
`define MHCD_LEVEL_TOP 8'hFE
`define MHCD_SCENE_NONE 8'hFF
`define MHCD_LMIN_RST 8'h01
`define MHCD_LMAX_RST 8'hFE
`define MHCD_FADE_RST 16'h000A
`define MHCD_ADR_LIMITS 8'h00
`define MHCD_ADR_FADE 8'h04
`define MHCD_ADR_LAMP 8'h08
`define MHCD_ADR_ECHO 8'h0C
`define MHCD_ADR_GROUP 8'h10
`define MHCD_ADR_STAT 8'h14
`endif

// ===== design/mhcd_mem.sv
// word memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module mhcd_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];
  // write port and registered read port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : mhcd_mem
`default_nettype wire

// ===== design/mhcd_pkg.sv
// types shared by the command decoder files
`include "mhcd_consts.svh"
package mhcd_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_DISP = 7'h02,
    S_RC = 7'h04,
    S_MRD = 7'h08,
    S_MWR = 7'h10,
    S_SEQ = 7'h20,
    S_PLC = 7'h40
  } mhcd_fsm_t;
  typedef struct packed {
    logic [15:0] dst;
    logic [15:0] cmd;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] p2;
  } mhcd_pkt_t;
  typedef struct packed {
    mhcd_fsm_t fsm;
    mhcd_fsm_t nxt;
    logic [4:0] widx;
    logic [15:0] cmd, p1, p2, p3, p4, idx, tmp, rc;
    logic [1:0] ph;
    logic [4:0] sidx, send;
    logic ov;
    logic [15:0] ow, pace;
    logic [`MHCD_N_LINK-1:0][15:0] link;
    logic [`MHCD_N_ERR-1:0][15:0] ber;
    logic txv;
    mhcd_pkt_t tx;
    logic [15:0] eaddr;
    logic [3:0] flood;
    logic [9:0] acc;
    logic fpend;
    logic [7:0] level, target, lmin, lmax, win;
    logic lit, offa;
    logic [15:0] fcnt, fade, grp;
    logic [15:0][7:0] scene;
    logic wack;
    logic [31:0] wdat;
  } mhcd_st_t;
endpackage : mhcd_pkg

// ===== design/mhcd_tick.sv
// periodic one-cycle tick generator
`timescale 1ns/10ps
`default_nettype none
module mhcd_tick #(
  parameter int PERIOD = 100000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_q;
  // count PERIOD cycles, pulse on the last
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q == 32'(PERIOD - 1));
      cnt_q <= (cnt_q == 32'(PERIOD - 1)) ? 32'h0 : cnt_q + 32'h1;
    end
  end
endmodule : mhcd_tick
`default_nettype wire

// ===== design/mhcd_top.sv
// host command frame decoder with lamp, echo and statistics logic
//
// The address map and the Wishbone register port were left to the implementer.
`include "mhcd_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - command 1 reads address list or block
// - count means sixteen-bit words
// - list read at most 29, addresses parms 3-31
// - command 2 mode 0 writes address/data pairs
// - command 2 mode 1 fills a block
// - status clears arrays or returns them
// - command A sets setpoint, fades by time
// - low nonzero setpoint stops at lower limit
// - setpoint above upper limit stops there
// - setpoint 0 fades down then off
// - serial lamp always, power-line only if addressed
// - command B codes 0, 1, 2
// - codes 3-4 step when lit, 5-6 jump
// - code 7 steps down/off, 8 ignites/steps up
// - scene fade, store, remove, group edits
// - reserved and high codes do nothing
// - command C sends power-line message
// - command D sets flood packet rate
// - command 20 sets echo address, rate, flags
// - flood packets carry echo requests
// - echo request addressed, sent counter bumped
// - received echo request answered, counted
// - 32-word frame in, return code reply
// - link paced at 115.2 kbps, 8N1
// - received echo acknowledge counted
module mhcd_top import mhcd_pkg::*; #(
  parameter int DMEM_AW = 10,
  parameter int MS_CYC = `MHCD_CLK_HZ / `MHCD_MS_PER_S,
  parameter int WORD_CYC = `MHCD_CLK_HZ / `MHCD_BAUD * `MHCD_BITS_PER_WORD
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic frame_valid_i,
  input wire logic [15:0] frame_word_i,
  output logic frame_ready_o,
  output logic reply_valid_o,
  output logic [15:0] reply_word_o,
  input wire logic reply_ready_i,
  input wire logic [15:0] node_addr_i,
  input wire logic plc_rx_valid_i,
  input wire mhcd_pkt_t plc_rx_i,
  output logic plc_rx_ready_o,
  output logic plc_tx_valid_o,
  output mhcd_pkt_t plc_tx_o,
  input wire logic plc_tx_ready_i,
  input wire logic [`MHCD_N_LINK-1:0] link_evt_i,
  output logic [7:0] lamp_level_o,
  output logic on_lamp_o
);
  mhcd_st_t q, d;
  logic ms_tick, rx_take, emit, lgo, ldir, fwe, dwe, fset;
  logic [15:0] ew;
  logic [7:0] lval, scn;
  logic [4:0] fwa, fra;
  logic [15:0] fwd, dwd, frd, drd, seqw;
  logic [DMEM_AW-1:0] dwa, dra;
  logic [`MHCD_N_ERR-1:0] berv;

  // frame store and target memory
  mhcd_mem #(.AW(5), .DW(16)) u_frame (
    .clk_i(clk_i), .we_i(fwe), .waddr_i(fwa), .wdata_i(fwd), .raddr_i(fra), .rdata_o(frd)
  );
  mhcd_mem #(.AW(DMEM_AW), .DW(16)) u_data (
    .clk_i(clk_i), .we_i(dwe), .waddr_i(dwa), .wdata_i(dwd), .raddr_i(dra), .rdata_o(drd)
  );
  mhcd_tick #(.PERIOD(MS_CYC)) u_ms (.clk_i(clk_i), .rst_i(rst_i), .tick_o(ms_tick));

  // handshakes and registered outputs
  assign frame_ready_o = (q.fsm == S_IDLE);
  assign plc_rx_ready_o = (q.fsm != S_DISP) && !q.txv;
  assign rx_take = plc_rx_valid_i && plc_rx_ready_o;
  assign reply_valid_o = q.ov;
  assign reply_word_o = q.ow;
  assign plc_tx_valid_o = q.txv;
  assign plc_tx_o = q.tx;
  assign lamp_level_o = q.level;
  assign on_lamp_o = q.lit;
  assign wb_ack_o = q.wack;
  assign wb_dat_o = q.wdat;
  assign scn = q.scene[lval[3:0]];

  // status sequence word: count, link stats, error counters, node address
  always_comb begin
    if (q.sidx == 5'h00) begin
      seqw = `MHCD_SEQ_COUNT;
    end else if (q.sidx < `MHCD_SEQ_ERR0) begin
      seqw = q.link[4'(q.sidx - 5'h01)];
    end else if (q.sidx <= `MHCD_SEQ_LAST) begin
      seqw = q.ber[2'(q.sidx - `MHCD_SEQ_ERR0)];
    end else begin
      seqw = node_addr_i;
    end
  end

  // next-state logic
  always_comb begin
    d = q;
    emit = 1'b0;
    ew = 16'h0000;
    lgo = 1'b0;
    ldir = 1'b0;
    lval = 8'h00;
    fwe = 1'b0;
    fwa = 5'h00;
    fwd = 16'h0000;
    fra = 5'h00;
    dwe = 1'b0;
    dwa = '0;
    dwd = 16'h0000;
    dra = '0;
    berv = '0;
    fset = 1'b0;
    // wishbone slave, one wait state, unmapped reads zero
    d.wack = wb_cyc_i && wb_stb_i && !q.wack;
    if (wb_cyc_i && wb_stb_i && !q.wack) begin
      if (wb_we_i && wb_adr_i == `MHCD_ADR_LIMITS) begin
        if (wb_sel_i[0]) d.lmin = wb_dat_i[7:0];
        if (wb_sel_i[1]) d.lmax = wb_dat_i[15:8];
      end
      if (wb_we_i && wb_adr_i == `MHCD_ADR_FADE) begin
        if (wb_sel_i[0]) d.fade[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) d.fade[15:8] = wb_dat_i[15:8];
      end
      case (wb_adr_i)
        `MHCD_ADR_LIMITS: d.wdat = {16'h0000, q.lmax, q.lmin};
        `MHCD_ADR_FADE: d.wdat = {16'h0000, q.fade};
        `MHCD_ADR_LAMP: d.wdat = {23'h000000, q.lit, q.level};
        `MHCD_ADR_ECHO: d.wdat = {12'h000, q.flood, q.eaddr};
        `MHCD_ADR_GROUP: d.wdat = {16'h0000, q.grp};
        `MHCD_ADR_STAT: d.wdat = {q.rc, 9'h000, q.fsm};
        default: d.wdat = 32'h00000000;
      endcase
    end
    // reply word pacing at the serial word time
    if (q.pace != 16'h0000) d.pace = q.pace - 16'h0001;
    if (q.ov && reply_ready_i) d.ov = 1'b0;
    if (q.txv && plc_tx_ready_i) d.txv = 1'b0;
    // millisecond housekeeping: flood rate, fade window, fade steps
    if (ms_tick) begin
      if (q.flood != 4'h0) begin
        if (11'(q.acc) + 11'(q.flood) >= `MHCD_FLOOD_WRAP) begin
          d.acc = 10'(11'(q.acc) + 11'(q.flood) - `MHCD_FLOOD_WRAP);
          d.fpend = 1'b1;
          fset = 1'b1;
        end else begin
          d.acc = q.acc + 10'(q.flood);
        end
      end
      if (q.win != 8'h00) begin
        d.win = q.win - 8'h01;
        if (q.win == 8'h01) d.target = q.level;
      end
      if (q.fcnt + 16'h0001 >= q.fade) begin
        d.fcnt = 16'h0000;
        if (q.lit && q.level < q.target) begin
          d.level = q.level + 8'h01;
        end else if (q.lit && q.level > q.target) begin
          d.level = q.level - 8'h01;
        end else if (q.lit && q.offa && q.level <= q.lmin) begin
          d.lit = 1'b0;
          d.level = 8'h00;
          d.target = 8'h00;
          d.offa = 1'b0;
        end
      end else begin
        d.fcnt = q.fcnt + 16'h0001;
      end
    end
    // power-line receive: only traffic for this node acts
    if (rx_take && plc_rx_i.dst == node_addr_i) begin
      case (plc_rx_i.cmd)
        `MHCD_CMD_DLAMP: begin
          lgo = 1'b1;
          ldir = 1'b1;
          lval = plc_rx_i.p0[7:0];
        end
        `MHCD_CMD_LAMP: begin
          lgo = 1'b1;
          lval = plc_rx_i.p0[7:0];
        end
        `MHCD_CMD_ECHOREQ: begin
          d.txv = 1'b1;
          d.tx = '{dst: {plc_rx_i.p0[7:0], plc_rx_i.p1[7:0]}, cmd: `MHCD_CMD_ECHOACK,
                   p0: {8'h00, node_addr_i[15:8]}, p1: {8'h00, node_addr_i[7:0]}, p2: 16'h0000};
          berv[1] = 1'b1;
        end
        `MHCD_CMD_ECHOACK: berv[2] = 1'b1;
        default: ;
      endcase
    end
    // command sequencer
    case (q.fsm)
      S_IDLE: begin
        if (frame_valid_i) begin
          fwe = 1'b1;
          fwa = q.widx;
          fwd = frame_word_i;
          case (q.widx)
            5'h00: d.cmd = frame_word_i;
            5'h01: d.p1 = frame_word_i;
            5'h02: d.p2 = frame_word_i;
            5'h03: d.p3 = frame_word_i;
            5'h04: d.p4 = frame_word_i;
            default: ;
          endcase
          d.widx = q.widx + 5'h01;
          if (q.widx == `MHCD_FRAME_LAST) d.fsm = S_DISP;
        end
      end
      S_DISP: begin
        d.rc = `MHCD_RC_OK;
        d.fsm = S_RC;
        d.nxt = S_IDLE;
        d.idx = 16'h0000;
        d.ph = 2'h0;
        case (q.cmd)
          `MHCD_CMD_RDMEM: begin
            if (!q.p1[0] && q.p2 > `MHCD_LIST_MAX) d.rc = `MHCD_RC_BADCNT;
            else if (q.p2 != 16'h0000) d.nxt = S_MRD;
          end
          `MHCD_CMD_WRMEM: begin
            if (!q.p1[0] && q.p2 > `MHCD_PAIR_MAX) d.rc = `MHCD_RC_BADCNT;
            else if (q.p2 != 16'h0000) d.fsm = S_MWR;
          end
          `MHCD_CMD_STAT: begin
            if (q.p1 == 16'h0001) begin
              d.link = '0;
              d.ber = '0;
            end else begin
              d.nxt = S_SEQ;
              d.sidx = 5'h00;
              d.send = `MHCD_SEQ_LAST;
            end
          end
          `MHCD_CMD_DLAMP: begin
            lgo = 1'b1;
            ldir = 1'b1;
            lval = q.p1[7:0];
          end
          `MHCD_CMD_LAMP: begin
            lgo = 1'b1;
            lval = q.p1[7:0];
          end
          `MHCD_CMD_PLCMSG: d.fsm = S_PLC;
          `MHCD_CMD_FLOOD: d.flood = (q.p1 > `MHCD_FLOOD_MAX) ? 4'hF : q.p1[3:0];
          `MHCD_CMD_GETADDR: begin
            d.nxt = S_SEQ;
            d.sidx = `MHCD_SEQ_ADDR;
            d.send = `MHCD_SEQ_ADDR;
          end
          `MHCD_CMD_ECHOSET: begin
            d.eaddr = q.p2;
            d.flood = (q.p3 > `MHCD_FLOOD_MAX) ? 4'hF : q.p3[3:0];
            if (q.p3 == 16'h0000) d.flood = 4'h1;
            if (q.p1[0]) d.ber = '0;
            if (q.p1[1]) begin
              d.nxt = S_SEQ;
              d.sidx = `MHCD_SEQ_ERR0;
              d.send = `MHCD_SEQ_LAST;
            end
          end
          default: d.rc = `MHCD_RC_BADCMD;
        endcase
      end
      S_RC: begin
        if (!q.ov && q.pace == 16'h0000) begin
          emit = 1'b1;
          ew = q.rc;
          d.fsm = q.nxt;
        end
      end
      S_MRD: begin
        case (q.ph)
          2'h0: begin
            fra = 5'(q.idx) + 5'h03;
            d.ph = 2'h1;
          end
          2'h1: begin
            d.tmp = q.p1[0] ? q.p3 + q.idx : frd;
            dra = DMEM_AW'(d.tmp);
            d.ph = 2'h2;
          end
          default: begin
            dra = DMEM_AW'(q.tmp);
            if (!q.ov && q.pace == 16'h0000) begin
              emit = 1'b1;
              ew = drd;
              d.idx = q.idx + 16'h0001;
              d.ph = 2'h0;
              if (q.idx + 16'h0001 == q.p2) d.fsm = S_IDLE;
            end
          end
        endcase
      end
      S_MWR: begin
        if (q.p1[0]) begin
          dwe = 1'b1;
          dwa = DMEM_AW'(q.p3 + q.idx);
          dwd = q.p4;
          d.idx = q.idx + 16'h0001;
          if (q.idx + 16'h0001 == q.p2) d.fsm = S_RC;
        end else begin
          case (q.ph)
            2'h0: begin
              fra = 5'(q.idx << 1) + 5'h03;
              d.ph = 2'h1;
            end
            2'h1: begin
              d.tmp = frd;
              fra = 5'(q.idx << 1) + 5'h04;
              d.ph = 2'h2;
            end
            default: begin
              dwe = 1'b1;
              dwa = DMEM_AW'(q.tmp);
              dwd = frd;
              d.idx = q.idx + 16'h0001;
              d.ph = 2'h0;
              if (q.idx + 16'h0001 == q.p2) d.fsm = S_RC;
            end
          endcase
        end
      end
      S_SEQ: begin
        if (!q.ov && q.pace == 16'h0000) begin
          emit = 1'b1;
          ew = seqw;
          d.sidx = q.sidx + 5'h01;
          if (q.sidx == q.send) d.fsm = S_IDLE;
        end
      end
      S_PLC: begin
        if (!q.txv && !rx_take) begin
          d.txv = 1'b1;
          d.tx = '{dst: {q.p1[7:0], q.p2[7:0]}, cmd: q.p3, p0: q.p4, p1: 16'h0000,
                   p2: 16'h0000};
          d.fsm = S_RC;
        end
      end
      default: d.fsm = S_IDLE;
    endcase
    // flood packet carries an echo request when the transmitter is free
    if (q.fpend && !q.txv && !d.txv) begin
      d.fpend = fset; // a tick landing in the same cycle stays pending
      d.txv = 1'b1;
      d.tx = '{dst: q.eaddr, cmd: `MHCD_CMD_ECHOREQ, p0: {8'h00, node_addr_i[15:8]},
               p1: {8'h00, node_addr_i[7:0]}, p2: `MHCD_CMD_ECHOACK};
      berv[0] = 1'b1;
    end
    // lamp actions, direct setpoint or lighting code
    if (lgo && ldir) begin
      d.win = 8'h00;
      if (lval == 8'h00) begin
        d.target = q.lmin;
        d.offa = q.lit;
      end else begin
        d.offa = 1'b0;
        if (!q.lit) begin
          d.lit = 1'b1;
          d.level = q.lmin;
        end
        if (lval < q.lmin) d.target = q.lmin;
        else if (lval >= q.lmax && lval <= `MHCD_LEVEL_TOP) d.target = q.lmax;
        else if (lval > `MHCD_LEVEL_TOP) d.target = q.lmax;
        else d.target = lval;
      end
    end else if (lgo) begin
      case (lval)
        8'h00: begin
          d.lit = 1'b0;
          d.level = 8'h00;
          d.target = 8'h00;
          d.win = 8'h00;
        end
        8'h01, 8'h02: begin
          if (q.lit) begin
            d.target = (lval == 8'h01) ? q.lmax : q.lmin;
            d.win = `MHCD_FADE_WIN_MS;
            d.offa = 1'b0;
          end
        end
        8'h03: if (q.lit && q.level < q.lmax) d.level = q.level + 8'h01;
        8'h04: if (q.lit && q.level > q.lmin) d.level = q.level - 8'h01;
        8'h05, 8'h06: begin
          d.lit = 1'b1;
          d.level = (lval == 8'h05) ? q.lmax : q.lmin;
        end
        8'h07: begin
          if (q.lit && q.level <= q.lmin) begin
            d.lit = 1'b0;
            d.level = 8'h00;
          end else if (q.lit) begin
            d.level = q.level - 8'h01;
          end
        end
        8'h08: begin
          if (!q.lit) begin
            d.lit = 1'b1;
            d.level = q.lmin;
          end else if (q.level < q.lmax) begin
            d.level = q.level + 8'h01;
          end
        end
        default: begin
          case (lval[7:4])
            4'h1: begin
              if (scn != `MHCD_SCENE_NONE) begin
                if (!q.lit) begin
                  d.lit = 1'b1;
                  d.level = q.lmin;
                end
                d.target = scn;
              end
            end
            4'h4: d.scene[lval[3:0]] = q.level;
            4'h5: d.scene[lval[3:0]] = `MHCD_SCENE_NONE;
            4'h6: d.grp[lval[3:0]] = 1'b1;
            4'h7: d.grp[lval[3:0]] = 1'b0;
            default: ;
          endcase
        end
      endcase
      if (lval >= 8'h03 && lval <= 8'h08) d.target = d.level;
    end
    // emitted reply word and statistics counting, counts win over a clear
    if (emit) begin
      d.ov = 1'b1;
      d.ow = ew;
      d.pace = 16'(WORD_CYC - 1);
    end
    for (int i = 0; i < `MHCD_N_LINK; i++) d.link[i] = d.link[i] + 16'(link_evt_i[i]);
    for (int i = 0; i < `MHCD_N_ERR; i++) d.ber[i] = d.ber[i] + 16'(berv[i]);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.fsm <= S_IDLE;
      q.nxt <= S_IDLE;
      q.lmin <= `MHCD_LMIN_RST;
      q.lmax <= `MHCD_LMAX_RST;
      q.fade <= `MHCD_FADE_RST;
      q.scene <= '1;
    end else begin
      q <= d;
    end
  end

  // checks
  a_bad_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == 16'h0005) |=> (q.rc == `MHCD_RC_BADCMD && q.fsm == S_RC))
    else $error("unknown command did not give error code");
  a_list_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_RDMEM && !q.p1[0] && q.p2 > `MHCD_LIST_MAX)
    |=> (q.rc == `MHCD_RC_BADCNT && q.nxt == S_IDLE))
    else $error("oversized list read accepted");
  a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_STAT && q.p1 == 16'h0001)
    |=> (q.ber == '0 && q.link[0] <= 16'h0001))
    else $error("status arrays not cleared");
  a_low_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_DLAMP && q.p1[7:0] != 8'h00
     && q.p1[7:0] < q.lmin) |=> (q.target == $past(q.lmin)))
    else $error("low setpoint not raised to lower limit");
  a_high_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_DLAMP && q.p1[7:0] >= q.lmax
     && q.p1[7:0] >= q.lmin) |=> (q.target == $past(q.lmax)))
    else $error("high setpoint not held at upper limit");
  a_code_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_LAMP && q.p1[7:0] == 8'h00)
    |=> (!q.lit && q.level == 8'h00))
    else $error("lamp not switched off at once");
  a_recall_max: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == S_DISP && q.cmd == `MHCD_CMD_LAMP && q.p1[7:0] == 8'h05)
    |=> (q.lit && q.level == $past(q.lmax)))
    else $error("recall to upper limit failed");
  a_echo_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_take && plc_rx_i.dst == node_addr_i && plc_rx_i.cmd == `MHCD_CMD_ECHOREQ)
    |=> (q.txv && q.tx.cmd == `MHCD_CMD_ECHOACK && q.ber[1] == $past(q.ber[1]) + 16'h0001))
    else $error("echo request not answered");
  a_reply_pace: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.ov) |-> (q.pace == 16'(WORD_CYC - 1)))
    else $error("reply word not paced");
endmodule : mhcd_top
`default_nettype wire
